// file: strap_test_pkg.sv
package strap_test_pkg;
   // Number of device pins that the test logic can reach; one bit per package position.
   localparam int PIN_COUNT = 128;
   // Package position of the chain result output, counted from one.
   localparam int CHAIN_OUT_POS = 35;
   // Strap decode patterns for the two base-select straps.
   localparam logic [1:0] BASE_BOTH_LOW = 2'h0;
   localparam logic [1:0] BASE_BOTH_HIGH = 2'h3;
   // Reset values of the strap latches match the internal pull directions.
   localparam logic FLOAT_STRAP_RESET = 1'h1;
   localparam logic [1:0] BASE_STRAP_RESET = 2'h3;
   // Pin classes: bit set means the pin belongs to the class, index = position minus one.
   // Excluded pins are supplies, converter pins, dedicated inputs, reset and crystal pins.
   // The masks are board-specific and are parameters of the top with these defaults.
   localparam logic [PIN_COUNT-1:0] CHAIN_EXCLUDE_DEFAULT = 128'h0;
   localparam logic [PIN_COUNT-1:0] NEVER_FLOAT_DEFAULT = 128'h0;
   localparam logic [PIN_COUNT-1:0] PULLUP_DEFAULT = 128'h0;
   localparam logic [PIN_COUNT-1:0] NOPULL_DEFAULT = 128'h0;
   localparam logic [PIN_COUNT-1:0] STRAP_PIN_DEFAULT = 128'h0;

   // Test modes, one-hot.
   typedef enum logic [2:0] {
      MODE_NORMAL = 3'h1,
      MODE_XOR = 3'h2,
      MODE_FLOAT = 3'h4
   } test_mode_e;

   // Strap decode; the reserved combination falls back to normal operation.
   function automatic test_mode_e decodeMode(input logic floatStrap, input logic [1:0] baseStrap);
      if (floatStrap && baseStrap == BASE_BOTH_LOW) begin
         decodeMode = MODE_XOR;
      end else if (!floatStrap && baseStrap == BASE_BOTH_HIGH) begin
         decodeMode = MODE_FLOAT;
      end else begin
         decodeMode = MODE_NORMAL;
      end
   endfunction
endpackage

// file: strap_mode_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries the latched mode and the reset phase from the top to the chain module.
interface strap_mode_if;
   import strap_test_pkg::*;
   test_mode_e mode;
   logic coreReady;
   logic [PIN_COUNT-1:0] pinIn;
   logic chainResult;
   modport ctrl (output mode, output coreReady, output pinIn, input chainResult);
   modport chain (input mode, input coreReady, input pinIn, output chainResult);
endinterface
`default_nettype wire

// file: xor_chain.sv
`timescale 1ns/1ps
`default_nettype none
module xor_chain #(
   parameter logic [strap_test_pkg::PIN_COUNT-1:0] EXCLUDE = strap_test_pkg::CHAIN_EXCLUDE_DEFAULT
) (
   strap_mode_if.chain link // Mode, synchronised pin levels and chain result.
);
   import strap_test_pkg::*;

   // The chain is walked from the position after the output, upward, wrapping past
   // the last position to the first, ending at the output pin itself.
   // Being a pure parity, order does not change the result, but the walk is kept
   // so a ripple structure matches the board's expectation.
   always_comb begin
      logic acc;
      int pos;
      acc = 1'b0;
      pos = 0;
      for (int k = 0; k < PIN_COUNT; k++) begin
         pos = (CHAIN_OUT_POS + k) % PIN_COUNT;
         if (!EXCLUDE[pos] && pos != CHAIN_OUT_POS - 1) begin
            acc = acc ^ link.pinIn[pos];
         end
      end
      link.chainResult = acc;
   end
endmodule // xor_chain
`default_nettype wire

// file: strap_board_test_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module strap_board_test_mode_control #(
   parameter logic [strap_test_pkg::PIN_COUNT-1:0] CHAIN_EXCLUDE =
      strap_test_pkg::CHAIN_EXCLUDE_DEFAULT, // Pins kept out of the chain.
   parameter logic [strap_test_pkg::PIN_COUNT-1:0] NEVER_FLOAT =
      strap_test_pkg::NEVER_FLOAT_DEFAULT, // Pins that stay driven in float mode.
   parameter logic [strap_test_pkg::PIN_COUNT-1:0] PULLUP_PINS =
      strap_test_pkg::PULLUP_DEFAULT, // Keyscan inputs.
   parameter logic [strap_test_pkg::PIN_COUNT-1:0] NOPULL_PINS =
      strap_test_pkg::NOPULL_DEFAULT, // Bus clock, bus reset, bus frame.
   parameter logic [strap_test_pkg::PIN_COUNT-1:0] STRAP_PINS =
      strap_test_pkg::STRAP_PIN_DEFAULT // Pins that carry strap options.
) (
   input wire logic ref_clk, // Core clock, 125 MHz.
   input wire logic resetn, // Asynchronous core-domain reset, active low.
   input wire logic captureReset, // High while the reset is power-up or external POR.
   input wire logic coreResetDone, // Internal core reset sequence finished.
   input wire logic floatSelectStrap, // Float-select strap pin level.
   input wire logic baseSelectStrapHigh, // Base-select strap, upper pin level.
   input wire logic baseSelectStrapLow, // Base-select strap, lower pin level.
   input wire logic [strap_test_pkg::PIN_COUNT-1:0] pinIn, // Pad input levels.
   input wire logic [strap_test_pkg::PIN_COUNT-1:0] funcOut, // Functional output data.
   input wire logic [strap_test_pkg::PIN_COUNT-1:0] funcOe, // Functional output enables.
   input wire logic [strap_test_pkg::PIN_COUNT-1:0] funcPullUp, // Functional pull-up enables.
   input wire logic [strap_test_pkg::PIN_COUNT-1:0] funcPullDown, // Functional pull-down enables.
   output logic [strap_test_pkg::PIN_COUNT-1:0] padOut, // Pad output data.
   output logic [strap_test_pkg::PIN_COUNT-1:0] padOe, // Pad output enables, high drives.
   output logic [strap_test_pkg::PIN_COUNT-1:0] padPullUp, // Pad pull-up enables.
   output logic [strap_test_pkg::PIN_COUNT-1:0] padPullDown, // Pad pull-down enables.
   output logic [strap_test_pkg::PIN_COUNT-1:0] coreIn, // Pin levels seen by core logic.
   output logic [2:0] testMode // Latched one-hot mode.
);
   import strap_test_pkg::*;

   typedef struct packed {
      logic [2:0] strapSync1;
      logic [2:0] strapSync2;
      logic [1:0] readySync;
      logic captureWindow;
      logic floatStrap;
      logic [1:0] baseStrap;
      logic [PIN_COUNT-1:0] pinSync1;
      logic [PIN_COUNT-1:0] pinSync2;
      logic [PIN_COUNT-1:0] padOut;
      logic [PIN_COUNT-1:0] padOe;
      logic [PIN_COUNT-1:0] padPullUp;
      logic [PIN_COUNT-1:0] padPullDown;
      logic [PIN_COUNT-1:0] coreIn;
      logic [2:0] testMode;
   } state_s;

   state_s cur;
   state_s next_cur;
   strap_mode_if modeLink ();

   localparam logic [PIN_COUNT-1:0] OUT_ONEHOT = PIN_COUNT'(1) << (CHAIN_OUT_POS - 1);

   assign modeLink.mode = test_mode_e'(cur.testMode);
   assign modeLink.coreReady = cur.readySync[1];
   assign modeLink.pinIn = cur.pinSync2;

   xor_chain #(.EXCLUDE(CHAIN_EXCLUDE)) chainUnit (
      .link(modeLink)
   );

   // Next-state logic. Strap and pad levels cross two flops before any use.
   always_comb begin
      test_mode_e mode;
      logic [PIN_COUNT-1:0] chained;
      mode = test_mode_e'(cur.testMode);
      chained = ~CHAIN_EXCLUDE;
      next_cur = cur;
      next_cur.strapSync1 = {floatSelectStrap, baseSelectStrapHigh, baseSelectStrapLow};
      next_cur.strapSync2 = cur.strapSync1;
      next_cur.readySync = {cur.readySync[0], coreResetDone};
      next_cur.pinSync1 = pinIn;
      next_cur.pinSync2 = cur.pinSync1;
      // Capture after release only if the reset was of the capturing kind; the
      // level is sampled on every cycle of the window, here, never loaded by the asynchronous reset.
      next_cur.captureWindow = 1'b0;
      if (cur.captureWindow) begin
         next_cur.floatStrap = cur.strapSync2[2];
         next_cur.baseStrap = cur.strapSync2[1:0];
         next_cur.testMode = decodeMode(cur.strapSync2[2], cur.strapSync2[1:0]);
      end
      // Default: functional pass-through.
      next_cur.padOut = funcOut;
      next_cur.padOe = funcOe;
      next_cur.padPullUp = funcPullUp;
      next_cur.padPullDown = funcPullDown;
      next_cur.coreIn = cur.pinSync2;
      if (cur.captureWindow) begin
         // Strap pins float with their pulls while levels settle.
         next_cur.padOe = funcOe & ~STRAP_PINS;
      end else if (cur.readySync[1]) begin
         unique case (mode)
            MODE_FLOAT: begin
               next_cur.padOe = funcOe & NEVER_FLOAT;
            end
            MODE_XOR: begin
               next_cur.coreIn = '0;
               next_cur.padOe = OUT_ONEHOT;
               next_cur.padOut = {PIN_COUNT{modeLink.chainResult}} & OUT_ONEHOT;
               next_cur.padPullUp = chained & PULLUP_PINS;
               next_cur.padPullDown = chained & ~PULLUP_PINS & ~NOPULL_PINS;
            end
            MODE_NORMAL: begin
            end
         endcase
      end
   end

   // Single state register; reset loads constants only.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cur <= '0;
         cur.captureWindow <= 1'b0;
         cur.floatStrap <= FLOAT_STRAP_RESET;
         cur.baseStrap <= BASE_STRAP_RESET;
         cur.testMode <= MODE_NORMAL;
      end else begin
         cur <= next_cur;
         // Arm capture on every edge after a capturing reset until readySync sees coreResetDone; captureReset is
         // held by the reset controller across release, so sampling it here is safe.
         if (captureReset && !cur.readySync[1] && !cur.readySync[0]) begin
            cur.captureWindow <= 1'b1;
         end
      end
   end

   assign padOut = cur.padOut;
   assign padOe = cur.padOe;
   assign padPullUp = cur.padPullUp;
   assign padPullDown = cur.padPullDown;
   assign coreIn = cur.coreIn;
   assign testMode = cur.testMode;
endmodule // strap_board_test_mode_control
`default_nettype wire

// file: strap_mode_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the mode after reset and its hold, and of the test-mode pad overrides.
module strap_mode_props #(
   parameter logic [strap_test_pkg::PIN_COUNT-1:0] CHAIN_EXCLUDE = '0, // Unchained pins.
   parameter logic [strap_test_pkg::PIN_COUNT-1:0] NEVER_FLOAT = '0, // Exempt from float mode.
   parameter logic [strap_test_pkg::PIN_COUNT-1:0] PULLUP_PINS = '0, // Keyscan pins.
   parameter logic [strap_test_pkg::PIN_COUNT-1:0] NOPULL_PINS = '0 // Bus pins.
) (
   input wire logic ref_clk, // Clock.
   input wire logic resetn, // Reset.
   input wire logic captureReset, // Capture reset.
   input wire logic coreResetDone, // Core reset over.
   input wire logic [strap_test_pkg::PIN_COUNT-1:0] pinIn, // Pads in.
   input wire logic [strap_test_pkg::PIN_COUNT-1:0] funcOe, // Core enables.
   input wire logic [strap_test_pkg::PIN_COUNT-1:0] padOut, // Pads out.
   input wire logic [strap_test_pkg::PIN_COUNT-1:0] padOe, // Pad enables.
   input wire logic [strap_test_pkg::PIN_COUNT-1:0] padPullUp, // Pull-ups.
   input wire logic [strap_test_pkg::PIN_COUNT-1:0] coreIn, // To core.
   input wire logic [2:0] testMode // Mode.
);
   import strap_test_pkg::*;
   localparam logic [PIN_COUNT-1:0] OUTB = 128'h1 << (CHAIN_OUT_POS - 1);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Six settled cycles cover the three-edge delay of the pad override.
   sequence s_xor; (testMode == 3'h2 && coreResetDone) [*6]; endsequence
   sequence s_flt; (testMode == 3'h4 && coreResetDone) [*6]; endsequence
   property p_start; $rose(resetn) |-> testMode == 3'h1; endproperty
   a_start: assert property (p_start) else $error("mode not normal after reset");
   property p_hold; (!captureReset) [*2] |=> $stable(testMode); endproperty
   a_hold: assert property (p_hold) else $error("mode changed without capture");
   property p_xorOut;
      s_xor |-> padOut[CHAIN_OUT_POS-1] == ^($past(pinIn, 3) & ~CHAIN_EXCLUDE & ~OUTB);
   endproperty
   a_xorOut: assert property (p_xorOut) else $error("chain result wrong");
   property p_xorOe; s_xor |-> (padOe & ~CHAIN_EXCLUDE) == OUTB; endproperty
   a_xorOe: assert property (p_xorOe) else $error("chain enables wrong");
   property p_xorCore; s_xor |-> coreIn == '0; endproperty
   a_xorCore: assert property (p_xorCore) else $error("core sees chained pins");
   property p_xorPull;
      s_xor |-> (padPullUp & (PULLUP_PINS | NOPULL_PINS)) == (PULLUP_PINS & ~CHAIN_EXCLUDE);
   endproperty
   a_xorPull: assert property (p_xorPull) else $error("chain pull-ups wrong");
   property p_fltOe; s_flt |-> (padOe & ~NEVER_FLOAT) == '0; endproperty
   a_fltOe: assert property (p_fltOe) else $error("float mode drives a pin");
   property p_pass; (testMode == 3'h1) [*2] |-> padOe == $past(funcOe); endproperty
   a_pass: assert property (p_pass) else $error("normal enables not passed");
   c_xor: cover property (s_xor);
   c_flt: cover property (s_flt);
   c_norm: cover property (testMode == 3'h1 && coreResetDone);
endmodule // strap_mode_props
bind strap_board_test_mode_control strap_mode_props #(.CHAIN_EXCLUDE(CHAIN_EXCLUDE),
   .NEVER_FLOAT(NEVER_FLOAT), .PULLUP_PINS(PULLUP_PINS), .NOPULL_PINS(NOPULL_PINS))
   u_props (.ref_clk(ref_clk), .resetn(resetn), .captureReset(captureReset),
   .coreResetDone(coreResetDone), .pinIn(pinIn), .funcOe(funcOe), .padOut(padOut),
   .padOe(padOe), .padPullUp(padPullUp), .coreIn(coreIn), .testMode(testMode));
`default_nettype wire

// file: board_tester.sv
`timescale 1ns/1ps
`default_nettype none
// Board tester that sets strap levels and pin patterns just after each edge.
module board_tester (
   input wire logic ref_clk, // Clock.
   input wire logic [2:0] strapReq, // Float, base high, base low.
   input wire logic [strap_test_pkg::PIN_COUNT-1:0] pinReq, // Pattern.
   output logic floatSelectStrap, // Float strap.
   output logic baseSelectStrapHigh, // Base strap, upper.
   output logic baseSelectStrapLow, // Base strap, lower.
   output logic [strap_test_pkg::PIN_COUNT-1:0] pinIn // Pad levels.
);
   import strap_test_pkg::*;
   // Registered so that the pads move only at a clock edge, after the sampling flops have read them.
   always_ff @(posedge ref_clk) begin
      {floatSelectStrap, baseSelectStrapHigh, baseSelectStrapLow} <= strapReq;
      pinIn <= pinReq;
   end
endmodule // board_tester
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import strap_test_pkg::*;
   localparam logic [PIN_COUNT-1:0] CHX = 128'h1, NFL = 128'h8, PUP = 128'h2, NPL = 128'h4;
   localparam logic [PIN_COUNT-1:0] OUTB = 128'h1 << (CHAIN_OUT_POS - 1);
   localparam logic [PIN_COUNT-1:0] PLAIN = ~(CHX | PUP | NPL | OUTB);
   logic ref_clk = 1'b0, resetn = 1'b0, captureReset = 1'b0, coreResetDone = 1'b0;
   logic [2:0] strapReq = 3'h7;
   logic [2:0] testMode;
   logic fStrap, bHigh, bLow;
   logic [PIN_COUNT-1:0] pinReq = '0, fOut = '0, fOe = '0, fPu = '0, fPd = '0, pinIn;
   logic [PIN_COUNT-1:0] padOut, padOe, padPullUp, padPullDown, coreIn;
   int err_count = 0, checks_done = 0;
   // Free-running 125 MHz core clock.
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   board_tester u_tester (.ref_clk(ref_clk), .strapReq(strapReq), .pinReq(pinReq),
      .floatSelectStrap(fStrap), .baseSelectStrapHigh(bHigh), .baseSelectStrapLow(bLow),
      .pinIn(pinIn));
   strap_board_test_mode_control #(.CHAIN_EXCLUDE(CHX), .NEVER_FLOAT(NFL),
      .PULLUP_PINS(PUP), .NOPULL_PINS(NPL)) u_dut (.ref_clk(ref_clk), .resetn(resetn),
      .captureReset(captureReset), .coreResetDone(coreResetDone), .floatSelectStrap(fStrap),
      .baseSelectStrapHigh(bHigh), .baseSelectStrapLow(bLow), .pinIn(pinIn), .funcOut(fOut),
      .funcOe(fOe), .funcPullUp(fPu), .funcPullDown(fPd), .padOut(padOut), .padOe(padOe),
      .padPullUp(padPullUp), .padPullDown(padPullDown), .coreIn(coreIn), .testMode(testMode));
   // Strap code {float, base high, base low}; the reserved codes fall back to normal.
   function automatic logic [2:0] expMode(input logic [2:0] s);
      return (s == 3'h4) ? 3'h2 : ((s == 3'h3) ? 3'h4 : 3'h1);
   endfunction
   task automatic chk(input logic [PIN_COUNT-1:0] got, input logic [PIN_COUNT-1:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Full reset with the given straps; the core reset ends four cycles after release.
   task automatic doReset(input logic [2:0] s, input logic cap);
      @(posedge ref_clk);
      resetn <= 1'b0;
      captureReset <= cap;
      coreResetDone <= 1'b0;
      strapReq <= s;
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      coreResetDone <= 1'b1;
      captureReset <= 1'b0;
      repeat (6) @(posedge ref_clk);
   endtask
   // New random pads and core controls, then time for sync and pad registers.
   task automatic drive();
      @(posedge ref_clk);
      pinReq <= {$urandom, $urandom, $urandom, $urandom};
      fOe <= {$urandom, $urandom, $urandom, $urandom};
      fOut <= {$urandom, $urandom, $urandom, $urandom};
      fPu <= {$urandom, $urandom, $urandom, $urandom};
      fPd <= {$urandom, $urandom, $urandom, $urandom};
      repeat (5) @(posedge ref_clk);
      #1;
   endtask
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Every strap code, then a reset that must not recapture the chain straps.
   initial begin
      void'($urandom(61129));
      for (int i = 0; i < 8; i++) begin
         doReset(i[2:0], 1'b1);
         chk(testMode, expMode(i[2:0]));
         repeat (4) begin
            drive();
            if (i == 4) begin
               chk(padOut[CHAIN_OUT_POS-1], ^(pinReq & ~CHX & ~OUTB));
               chk(padOe & ~CHX, OUTB);
               chk(coreIn, '0);
               chk(padPullDown & PLAIN, PLAIN);
               chk(padPullUp & (PUP | NPL), PUP);
            end else if (i == 3) begin
               chk(padOe & ~NFL, '0);
            end else begin
               chk(padOe, fOe);
            end
         end
      end
      doReset(3'h4, 1'b0);
      chk(testMode, 3'h1);
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
